// ### hw/ces_error_snoop.v
`timescale 1ns/1ps
`default_nettype none
`include "ces_defines.vh"

module ces_error_snoop (
    // Clock and reset
    input  wire clk_sys,
    input  wire nrst,
    // Clock-stop request pin, active low
    input  wire clockStopRequest_n,
    // Core event inputs, same clock domain
    input  wire fpErrorUnmasked,
    input  wire breakEventPending,
    input  wire internalErrorDetect,
    // Core snoop interface, same clock domain
    input  wire snoopValid,
    input  wire snoopHitLine,
    input  wire snoopHitModLine,
    input  wire snoopNeedStall,
    output wire snoopStallSeen,
    output wire snoopResultValid,
    output wire snoopResultHit,
    output wire snoopResultHitMod,
    // Shutdown transaction request towards the bus unit
    output reg  shutdownReq_r,
    // Combined error / break pin, active low
    output reg  fp_error_break_event_out_n,
    // Internal error pin, active low
    output reg  internal_error_out_n,
    // Snoop hit pin, open drain, active low
    input  wire snoopHit_n_in,
    output reg  snoopHit_n_out,
    output reg  snoopHit_oe_n,
    // Snoop hit-modified pin, open drain, active low
    input  wire snoop_hit_modified_n_in,
    output reg  snoop_hit_modified_n_out,
    output reg  snoop_hit_modified_oe_n
);

    // ======================================================================
    // Pin synchronisers.
    // Three pins arrive from outside the clock domain: the clock-stop
    // request and the two shared snoop wires. Each passes two flip-flops,
    // and only the second stage is read, so a metastable first stage
    // never fans out into the decode logic.
    localparam SYNC_BITS = 3;

    wire [SYNC_BITS-1:0] pinRaw;
    wire [SYNC_BITS-1:0] pinSafe;

    assign pinRaw = {clockStopRequest_n, snoopHit_n_in, snoop_hit_modified_n_in};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_BITS; gi = gi + 1) begin : g_sync
            reg stage1_r;
            reg stage2_r;

            // Every pin idles high, so both stages reset high; a low reset
            // value would fake a stall or a clock-stop just after reset.
            always @(posedge clk_sys) begin
                if (!nrst) begin
                    stage1_r <= 1'h1;
                    stage2_r <= 1'h1;
                end else begin
                    stage1_r <= pinRaw[gi];
                    stage2_r <= stage1_r;
                end
            end

            assign pinSafe[gi] = stage2_r;
        end
    endgenerate

    // Active-high views of the synchronised pins.
    wire       clockStopActive;
    wire [1:0] busSnoop;

    assign clockStopActive = ~pinSafe[2];
    assign busSnoop        = {~pinSafe[1], ~pinSafe[0]};

    // ======================================================================
    // Combined floating-point error / break event output.
    // The meaning switches three cycles after the clock-stop pin moves,
    // because the pin is synchronised and the output is registered; the system
    // must allow for that lag before reading the pin in its new meaning.
    reg  fpBreak_nxt;

    always @* begin
        if (clockStopActive) begin
            fpBreak_nxt = breakEventPending;
        end else begin
            fpBreak_nxt = fpErrorUnmasked;
        end
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            fp_error_break_event_out_n <= 1'h1;
        end else begin
            fp_error_break_event_out_n <= ~fpBreak_nxt;
        end
    end

    // ======================================================================
    // Internal error.
    // The flag is sticky: only reset clears it, so a later detect has
    // nothing to add. The pin follows the detect one cycle later, even on
    // the first detect, by folding the live detect into the pin's value.
    reg  errSticky_r;

    always @(posedge clk_sys) begin
        if (!nrst) begin
            errSticky_r <= `CES_RST_LOW;
        end else if (internalErrorDetect) begin
            errSticky_r <= 1'h1;
        end
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            internal_error_out_n <= 1'h1;
        end else begin
            internal_error_out_n <= ~(errSticky_r | internalErrorDetect);
        end
    end

    // One request until the next reset: the bus unit would otherwise issue
    // a shutdown for every cycle the core keeps the detect high.
    always @(posedge clk_sys) begin
        if (!nrst) begin
            shutdownReq_r <= `CES_RST_LOW;
        end else begin
            shutdownReq_r <= internalErrorDetect & ~errSticky_r;
        end
    end

    // ======================================================================
    // Snoop result drive. A stall is driven as both pins low; holding the
    // stall request reasserts both pins each snoop window, extending it.
    // Hit-modified wins over a plain hit and is shown on its own pin only.
    reg  [1:0] drive_nxt;

    always @* begin
        drive_nxt = `CES_SNOOP_NONE;
        if (snoopValid) begin
            if (snoopNeedStall) begin
                drive_nxt = `CES_SNOOP_STALL;
            end else begin
                drive_nxt = {snoopHitLine & ~snoopHitModLine, snoopHitModLine};
            end
        end
    end

    // The pins are open drain: the data level is low out of reset and only the
    // enable decides, so a released pin falls back to its pull-up.
    always @(posedge clk_sys) begin
        if (!nrst) begin
            snoopHit_n_out           <= 1'h1;
            snoop_hit_modified_n_out <= 1'h1;
        end else begin
            snoopHit_n_out           <= 1'h0;
            snoop_hit_modified_n_out <= 1'h0;
        end
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            snoopHit_oe_n           <= 1'h1;
            snoop_hit_modified_oe_n <= 1'h1;
        end else begin
            snoopHit_oe_n           <= ~drive_nxt[1];
            snoop_hit_modified_oe_n <= ~drive_nxt[0];
        end
    end

    // ======================================================================
    // Snoop result seen on the shared wires.
    // Any agent, including this one, showing both pins low is a stall, and
    // a stall hides the hit bits so the core never mistakes it for a result.
    assign snoopStallSeen    = (busSnoop == `CES_SNOOP_STALL);
    assign snoopResultValid  = (busSnoop != `CES_SNOOP_STALL);
    assign snoopResultHit    = busSnoop[1] & ~snoopStallSeen;
    assign snoopResultHitMod = busSnoop[0] & ~snoopStallSeen;

endmodule // ces_error_snoop
`default_nettype wire

// ### hw/ces_defines.vh
`ifndef CES_DEFINES_VH
`define CES_DEFINES_VH

// ==========================================================================
// Snoop result encodings on the {hit, hitModified} pair, active high here.
`define CES_SNOOP_NONE     2'h0
`define CES_SNOOP_HIT_MOD  2'h1
`define CES_SNOOP_HIT      2'h2
`define CES_SNOOP_STALL    2'h3

// ==========================================================================
// Reset values.
`define CES_RST_LOW        1'h0

`endif

// ### tb/ces_error_snoop_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ces_chk (input wire logic clk_sys, nrst, clockStopRequest_n, fpErrorUnmasked,
    breakEventPending, internalErrorDetect, snoopValid, snoopHitModLine, snoopNeedStall,
    snoopStallSeen, shutdownReq_r, fp_error_break_event_out_n, internal_error_out_n,
    snoopHit_n_in, snoop_hit_modified_n_in, snoopHit_oe_n, snoop_hit_modified_oe_n);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    chk_fp_mode: assert property (clockStopRequest_n[*4] |=>
        fp_error_break_event_out_n == !$past(fpErrorUnmasked)) else $error("fp");
    chk_brk_mode: assert property ((!clockStopRequest_n)[*4] |=>
        fp_error_break_event_out_n == !$past(breakEventPending)) else $error("brk");
    chk_interr_set: assert property (internalErrorDetect |=>
        !internal_error_out_n) else $error("interr");
    chk_interr_hold: assert property (!internal_error_out_n |=>
        !internal_error_out_n) else $error("hold");
    chk_shut_pulse: assert property (internalErrorDetect && internal_error_out_n |=>
        shutdownReq_r ##1 !shutdownReq_r) else $error("shut");
    chk_stall_drive: assert property (snoopValid && snoopNeedStall |=>
        !snoopHit_oe_n && !snoop_hit_modified_oe_n) else $error("stall");
    chk_hitmod_drive: assert property (snoopValid && !snoopNeedStall && snoopHitModLine |=>
        !snoop_hit_modified_oe_n && snoopHit_oe_n) else $error("hitmod");
    chk_stall_seen: assert property (!snoopHit_n_in && !snoop_hit_modified_n_in |->
        ##2 snoopStallSeen) else $error("seen");
    cover property (shutdownReq_r);
    cover property (snoopStallSeen[*3]);
    cover property (!fp_error_break_event_out_n && !clockStopRequest_n);
endmodule // ces_chk
bind ces_error_snoop ces_chk u_chk (.*);
`default_nettype wire

// ### tb/ces_agent.sv
`timescale 1ns/1ps
`default_nettype none
module ces_agent (input wire logic clk, nrst, shutReq, hOe_n, hOut, mOe_n, mOut, aHit,
    aHitMod, output wire logic hPin_n, mPin_n, output logic nmiOut);
    // Pulled-up shared wires: any agent driving low wins.
    assign hPin_n = (hOe_n | hOut) & !aHit;
    assign mPin_n = (mOe_n | mOut) & !aHitMod;
    // Core logic turns the shutdown request into a held error interrupt.
    always @(posedge clk) nmiOut <= !nrst ? 1'b0 : (nmiOut | shutReq);
endmodule // ces_agent
`default_nettype wire

// ### tb/cpu_error_snoop_signalling_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_error_snoop_signalling_bench;
    logic clk_sys = 0, nrst = 0, clockStopRequest_n = 1, fpErrorUnmasked = 0,
        breakEventPending = 0, internalErrorDetect = 0, snoopValid = 0, snoopHitLine = 0,
        snoopHitModLine = 0, snoopNeedStall = 0, aHit = 0, aHitMod = 0;
    wire logic nmiSeen;
    wire logic snoopStallSeen, snoopResultValid, snoopResultHit, snoopResultHitMod,
        shutdownReq_r, fp_error_break_event_out_n, internal_error_out_n, snoopHit_n_in,
        snoopHit_n_out, snoopHit_oe_n, snoop_hit_modified_n_in, snoop_hit_modified_n_out,
        snoop_hit_modified_oe_n;
    int miscompares = 0, total_checks = 0;
    always #2 clk_sys = ~clk_sys;
    ces_error_snoop u_dut (.*);
    ces_agent u_agent (.clk(clk_sys), .nrst(nrst), .shutReq(shutdownReq_r),
        .hOe_n(snoopHit_oe_n), .hOut(snoopHit_n_out),
        .mOe_n(snoop_hit_modified_oe_n), .mOut(snoop_hit_modified_n_out), .aHit(aHit),
        .aHitMod(aHitMod), .hPin_n(snoopHit_n_in), .mPin_n(snoop_hit_modified_n_in),
        .nmiOut(nmiSeen));
    task automatic chk(input logic seen, exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t got %b", $time, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic t_flag;
        fpErrorUnmasked = 1; cyc(1); chk(fp_error_break_event_out_n, 1'h0);
        clockStopRequest_n = 0; cyc(4); chk(fp_error_break_event_out_n, 1'h1);
        breakEventPending = 1; cyc(1); chk(fp_error_break_event_out_n, 1'h0);
        clockStopRequest_n = 1; fpErrorUnmasked = 0; cyc(4);
        chk(fp_error_break_event_out_n, 1'h1);
        breakEventPending = 0;
    endtask
    task automatic t_snoop;
        snoopValid = 1; snoopNeedStall = 1; cyc(1);
        chk(snoopHit_oe_n | snoop_hit_modified_oe_n, 1'h0);
        snoopNeedStall = 0; snoopHitModLine = 1; cyc(1);
        chk(snoop_hit_modified_oe_n, 1'h0); chk(snoopHit_oe_n, 1'h1);
        snoopValid = 0; snoopHitModLine = 0; cyc(1); chk(snoopStallSeen, 1'h1);
        chk(snoopResultValid, 1'h0);
        cyc(1); chk(snoopResultHitMod, 1'h1); chk(snoopResultValid, 1'h1);
        aHit = 1; aHitMod = 1; cyc(2); chk(snoopStallSeen, 1'h1);
        aHitMod = 0; cyc(2); chk(snoopStallSeen, 1'h0); chk(snoopResultHit, 1'h1);
        aHit = 0;
    endtask
    task automatic t_internal_error_out;
        internalErrorDetect = 1; cyc(1); internalErrorDetect = 0;
        chk(internal_error_out_n, 1'h0); chk(shutdownReq_r, 1'h1);
        internalErrorDetect = 1; cyc(1); internalErrorDetect = 0;
        chk(shutdownReq_r, 1'h0); chk(nmiSeen, 1'h1);
        cyc(3); chk(internal_error_out_n, 1'h0);
        nrst = 0; cyc(1); nrst = 1; chk(internal_error_out_n, 1'h1);
    endtask
    initial begin
        cyc(5); nrst = 1; cyc(1);
        t_flag(); t_snoop(); t_internal_error_out(); cyc(2);
        end_of_test();
    end
endmodule // cpu_error_snoop_signalling_bench
`default_nettype wire
